// *** pkg/usr_params.svh ***
`ifndef USR_PARAMS_SVH
`define USR_PARAMS_SVH

// Register byte addresses
`define USR_ADDR_CTRL      8'h00
`define USR_ADDR_RX_FIFO_FULL_THRESHOLD     8'h04
`define USR_ADDR_STATUS    8'h08
`define USR_ADDR_RXDATA    8'h0c
`define USR_ADDR_STOPLEN   8'h10

// Control register fields
`define USR_CTRL_MODEM_BIT   0
`define USR_CTRL_EXT1X_BIT   1
`define USR_CTRL_CHAN1_BIT   2
`define USR_CTRL_WORD16_BIT  3
`define USR_CTRL_CHLEN_LSB   4

// Reset values
`define USR_RX_FIFO_FULL_THRESHOLD_RST     5'h00
`define USR_STOPCODE_RST  4'h7
`define USR_CTRL_RST      6'h34

// Bit timing in sixteenths
`define USR_SIXTEENTHS    5'h10
`define USR_STOP_MIN_68   5'h09
`define USR_STOP_MIN_5    5'h11

`endif

// *** pkg/usr_pkg.sv ***
package usr_pkg;
	// Packed from the top down so that bit 0 is modem and bits 5:4 the length
	typedef struct packed {
		logic [1:0] char_len;
		logic       word16;
		logic       chan_one;
		logic       ext_1x;
		logic       modem;
	} usr_ctrl_t;

	typedef enum logic [1:0] {
		USR_RX_IDLE,
		USR_RX_BITS,
		USR_RX_STOP
	} usr_rx_state_t;

	typedef struct packed {
		logic [4:0] stop_sixteenths;
		logic       stop_two_bits;
		logic       stop_active;
	} usr_stop_t;
endpackage

// *** src/usr_fifo.sv ***
`timescale 1ns/1ps
module usr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic               i_sys_clk,
	input  wire logic               i_rst_b,
	input  wire logic [WIDTH-1:0]   i_wr_data,
	input  wire logic               i_wr_valid,
	output logic                    o_wr_ready,
	output logic [WIDTH-1:0]        o_rd_data,
	output logic                    o_rd_valid,
	input  wire logic               i_rd_ready,
	output logic [$clog2(DEPTH):0]  o_count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
	logic [AW:0]      count_q, count_d;
	logic             push, pop;

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH) $error("usr_fifo depth must be a power of two");
	end

	// Handshake and pointer arithmetic
	always_comb begin
		push     = i_wr_valid && (count_q != (AW+1)'(DEPTH));
		pop      = i_rd_ready && (count_q != '0);
		wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
		rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
		count_d  = count_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q  <= count_d;
		end
	end

	// Storage, no reset needed
	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem[wr_ptr_q] <= i_wr_data;
		end
	end

	assign o_wr_ready = (count_q != (AW+1)'(DEPTH));
	assign o_rd_valid = (count_q != '0);
	assign o_rd_data  = mem[rd_ptr_q];
	assign o_count    = count_q;
endmodule

// *** src/usr_stop_rx_fifo_full_threshold.sv ***
// Functional notes
// - Transmit stop length covers 9/16 to 1 and 25/16 to 2 bits for 6-8 bit characters in sixteenth steps.
// - Code 0 gives 17/16 bits for 5-bit and 9/16 for wider characters, each code adding 1/16 except code 8, which adds 9/16 for wider characters.
// - The receiver samples the stop condition once, mid first stop bit after the last data bit.
// - With an external 1x clock, code bit 3 set gives two stop bits, clear gives one.
// - The stop length code is ignored in modem mode.
// - The receive threshold exists only on channel one and works in UART and modem modes.
// - Threshold is field plus one bytes; FIFO counts as full when bytes reach it.
// - FIFO moves whole samples of one or two bytes while thresholds count bytes.
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "usr_params.svh"
module usr_stop_rx_fifo_full_threshold
	import usr_pkg::*;
#(
	parameter int FIFO_DEPTH = 16,
	parameter int OVS        = 16
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_b,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [31:0] i_wb_dat,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic        i_wb_we,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	output logic [31:0]      o_wb_dat,
	output logic             o_wb_ack,
	input  wire logic        i_rx_pin,
	output logic [4:0]       o_stop_sixteenths,
	output logic             o_stop_two_bits,
	output logic             o_rx_full,
	output logic             o_rx_overrun
);
	localparam int CW = $clog2(FIFO_DEPTH);

	initial begin
		if (OVS != 16) $error("usr_stop_rx_fifo_full_threshold needs 16x oversampling");
		if (FIFO_DEPTH != 16) $error("usr_stop_rx_fifo_full_threshold sized for 16 sample FIFO");
	end

	// Bytes held for a sample count
	function automatic logic [6:0] bytes_of(input logic [CW:0] n, input logic w16);
		bytes_of = w16 ? 7'({n, 1'b0}) : 7'(n);
	endfunction

	usr_ctrl_t        ctrl_q, ctrl_d;
	logic [4:0]       rx_fifo_full_threshold_q, rx_fifo_full_threshold_d;
	logic [3:0]       stop_code_q, stop_code_d;
	logic [31:0]      rdat_q, rdat_d;
	logic             ack_q, ack_d;
	logic             full_q, full_d;
	logic             ovr_q, ovr_d;
	usr_stop_t        stop_q, stop_d;
	logic             rx_meta_q, rx_sync_q;
	usr_rx_state_t    st_q, st_d;
	logic [3:0]       tick_q, tick_d;
	logic [3:0]       bit_q, bit_d;
	logic [15:0]      shift_q, shift_d;
	logic [7:0]       hold_q, hold_d;
	logic             push_pend_q, push_pend_d;
	logic             frame_err_q, frame_err_d;
	logic [15:0]      f_wdata, f_rdata;
	logic             f_wvalid, f_wready, f_rvalid, f_rready;
	logic [CW:0]      f_count;
	logic             bus_req, rd_pop;

	// Stop length before the 1x and modem overrides, six bits so 2.0 fits
	logic [5:0]       stop_len;

	// Received character moved down to bit 0 for short lengths
	logic [7:0]       rx_byte;

	assign bus_req = i_wb_cyc && i_wb_stb && !ack_q;

	// Register writes and read mux
	always_comb begin
		ctrl_d      = ctrl_q;
		rx_fifo_full_threshold_d     = rx_fifo_full_threshold_q;
		stop_code_d = stop_code_q;
		rdat_d      = rdat_q;
		ack_d       = bus_req;
		rd_pop      = 1'b0;
		if (bus_req && i_wb_we && i_wb_sel[0]) begin
			case (i_wb_adr)
				`USR_ADDR_CTRL:    ctrl_d = usr_ctrl_t'(i_wb_dat[5:0]);
				`USR_ADDR_RX_FIFO_FULL_THRESHOLD:   rx_fifo_full_threshold_d = i_wb_dat[4:0];
				`USR_ADDR_STOPLEN: stop_code_d = i_wb_dat[3:0];
				default:           ;
			endcase
		end
		if (bus_req && !i_wb_we) begin
			case (i_wb_adr)
				`USR_ADDR_CTRL:    rdat_d = {26'h0, ctrl_q};
				`USR_ADDR_RX_FIFO_FULL_THRESHOLD:   rdat_d = {27'h0, rx_fifo_full_threshold_q};
				`USR_ADDR_STOPLEN: rdat_d = {28'h0, stop_code_q};
				`USR_ADDR_STATUS:  rdat_d = {24'h0, frame_err_q, ovr_q, full_q, f_rvalid,
					(4)'(f_count)};
				`USR_ADDR_RXDATA: begin
					rdat_d = {16'h0, f_rdata};
					rd_pop = f_rvalid;
				end
				default:           rdat_d = 32'h0;
			endcase
		end
	end

	// Transmit stop length decode
	always_comb begin
		// Upper codes share one column; 5-bit characters start half a bit higher
		if (stop_code_q[3] || ctrl_q.char_len == 2'b00) begin
			stop_len = 6'(`USR_STOP_MIN_5) + 6'(stop_code_q);
		end else begin
			stop_len = 6'(`USR_STOP_MIN_68) + 6'(stop_code_q);
		end
		stop_d.stop_active     = !ctrl_q.modem;
		// A full two bits is shown as two_bits with zero sixteenths
		stop_d.stop_two_bits   = stop_len[5];
		stop_d.stop_sixteenths = stop_len[4:0];
		if (ctrl_q.ext_1x) begin
			stop_d.stop_two_bits   = stop_code_q[3];
			stop_d.stop_sixteenths = stop_code_q[3] ? 5'h00 : `USR_SIXTEENTHS;
		end
		if (ctrl_q.modem) begin
			stop_d.stop_two_bits   = 1'b0;
			stop_d.stop_sixteenths = `USR_SIXTEENTHS;
		end
	end

	// Receiver: 8N1 style, sample width from control
	always_comb begin
		st_d        = st_q;
		tick_d      = tick_q + 4'h1;
		bit_d       = bit_q;
		shift_d     = shift_q;
		hold_d      = hold_q;
		push_pend_d = push_pend_q;
		frame_err_d = frame_err_q;
		ovr_d       = ovr_q;
		f_wvalid    = 1'b0;
		f_wdata     = shift_q;
		// Bits enter at the top, so short characters sit high in hold_q
		rx_byte     = hold_q >> (2'h3 - ctrl_q.char_len);
		if (push_pend_q) begin
			f_wvalid = 1'b1;
			if (f_wready) begin
				push_pend_d = 1'b0;
			end
		end
		case (st_q)
			USR_RX_IDLE: begin
				tick_d = 4'h0;
				if (!rx_sync_q) begin
					st_d   = USR_RX_BITS;
					tick_d = 4'h8;
					bit_d  = 4'h0;
				end
			end
			USR_RX_BITS: begin
				if (tick_q == 4'hf) begin
					if (bit_q != 4'h0) begin
						hold_d = {rx_sync_q, hold_q[7:1]};
					end
					bit_d = bit_q + 4'h1;
					// Last data bit is number 5 plus the length code
					if (bit_q == 4'h5 + {2'b00, ctrl_q.char_len}) begin
						st_d = USR_RX_STOP;
					end
				end
			end
			USR_RX_STOP: begin
				if (tick_q == 4'hf) begin
					st_d        = USR_RX_IDLE;
					frame_err_d = !rx_sync_q;
					if (ctrl_q.word16 && !shift_q[15]) begin
						shift_d = {1'b1, 7'h0, rx_byte};
					end else if (push_pend_q) begin
						ovr_d = 1'b1;
					end else begin
						push_pend_d = 1'b1;
						shift_d     = ctrl_q.word16 ? {rx_byte, shift_q[7:0]} : {8'h0, rx_byte};
					end
				end
			end
			default: st_d = USR_RX_IDLE;
		endcase
		if (push_pend_q && f_wready) begin
			shift_d = '0;
		end
	end

	// Byte threshold compare, channel one only
	always_comb begin
		full_d = ctrl_q.chan_one &&
			(bytes_of(f_count, ctrl_q.word16) >= 7'(rx_fifo_full_threshold_q) + 7'h1);
	end

	assign f_rready = rd_pop;

	usr_fifo #(
		.WIDTH(16),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_sys_clk  (i_sys_clk),
		.i_rst_b    (i_rst_b),
		.i_wr_data  (f_wdata),
		.i_wr_valid (f_wvalid),
		.o_wr_ready (f_wready),
		.o_rd_data  (f_rdata),
		.o_rd_valid (f_rvalid),
		.i_rd_ready (f_rready),
		.o_count    (f_count)
	);

	// Register bus and configuration state
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_q      <= usr_ctrl_t'(`USR_CTRL_RST);
			rx_fifo_full_threshold_q     <= `USR_RX_FIFO_FULL_THRESHOLD_RST;
			stop_code_q <= `USR_STOPCODE_RST;
			rdat_q      <= 32'h0;
			ack_q       <= 1'b0;
		end else begin
			ctrl_q      <= ctrl_d;
			rx_fifo_full_threshold_q     <= rx_fifo_full_threshold_d;
			stop_code_q <= stop_code_d;
			rdat_q      <= rdat_d;
			ack_q       <= ack_d;
		end
	end

	// Registered stop length and full flag outputs
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			full_q      <= 1'b0;
			stop_q      <= '0;
		end else begin
			full_q      <= full_d;
			stop_q      <= stop_d;
		end
	end

	// Receiver state, line idles high so the synchroniser resets high
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ovr_q       <= 1'b0;
			rx_meta_q   <= 1'b1;
			rx_sync_q   <= 1'b1;
			st_q        <= USR_RX_IDLE;
			tick_q      <= 4'h0;
			bit_q       <= 4'h0;
			shift_q     <= 16'h0;
			hold_q      <= 8'h0;
			push_pend_q <= 1'b0;
			frame_err_q <= 1'b0;
		end else begin
			ovr_q       <= ovr_d;
			rx_meta_q   <= i_rx_pin;
			rx_sync_q   <= rx_meta_q;
			st_q        <= st_d;
			tick_q      <= tick_d;
			bit_q       <= bit_d;
			shift_q     <= shift_d;
			hold_q      <= hold_d;
			push_pend_q <= push_pend_d;
			frame_err_q <= frame_err_d;
		end
	end

	assign o_wb_dat          = rdat_q;
	assign o_wb_ack          = ack_q;
	assign o_stop_sixteenths = stop_q.stop_sixteenths;
	assign o_stop_two_bits   = stop_q.stop_two_bits;
	assign o_rx_full         = full_q;
	assign o_rx_overrun      = ovr_q;
endmodule

// *** tb/usr_line_model.sv ***
`timescale 1ns/1ps
module usr_line_model (
	input  wire logic i_sys_clk,
	output logic      o_line
);
	// Idle line is pulled high
	initial o_line = 1'b1;
	// One frame: start low, data lsb first, one stop bit, 16 cycles a bit
	task automatic send(input logic [7:0] b, input int n);
		for (int k = -1; k <= n; k++) begin
			o_line <= (k < 0) ? 1'b0 : (k == n) ? 1'b1 : b[k];
			repeat (16) @(posedge i_sys_clk);
		end
	endtask
endmodule

// *** tb/usr_stop_rx_fifo_full_threshold_properties.sv ***
`timescale 1ns/1ps
module usr_stop_rx_fifo_full_threshold_props (
	input wire logic        i_sys_clk,
	input wire logic        i_rst_b,
	input wire logic [7:0]  i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0]  i_wb_sel,
	input wire logic        i_wb_we,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic [31:0] o_wb_dat,
	input wire logic        o_wb_ack,
	input wire logic        i_rx_pin,
	input wire logic [4:0]  o_stop_sixteenths,
	input wire logic        o_stop_two_bits,
	input wire logic        o_rx_full,
	input wire logic        o_rx_overrun
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	// Bus handshake and read data
	a_ack_follows_req: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("no ack after request");
	a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	a_ack_needs_req: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
		else $error("ack without request");
	a_level_upper_zero: assert property (o_wb_ack && $past(!i_wb_we && i_wb_adr == 8'h04)
		|-> o_wb_dat[31:5] == 27'h0)
		else $error("threshold upper bits set");
	a_unmapped_zero: assert property (o_wb_ack && $past(!i_wb_we && i_wb_adr > 8'h10)
		|-> o_wb_dat == 32'h0)
		else $error("unmapped read not zero");
	// Stop length outputs
	a_stop_floor: assert property (o_stop_sixteenths != 5'h00 |-> o_stop_sixteenths >= 5'h09)
		else $error("stop length below nine sixteenths");
	a_stop_by_write: assert property ($past(i_rst_b, 2) && !$stable(o_stop_sixteenths)
		|-> o_wb_ack || $past(o_wb_ack) || $past(o_wb_ack, 2))
		else $error("stop length changed without write");
	// Full flag drops only after a register access
	a_full_fall: assert property ($fell(o_rx_full) |-> o_wb_ack || $past(o_wb_ack)
		|| $past(o_wb_ack, 2) || $past(o_wb_ack, 3))
		else $error("full dropped without access");
endmodule
bind usr_stop_rx_fifo_full_threshold usr_stop_rx_fifo_full_threshold_props usr_stop_rx_fifo_full_threshold_props_i (.i_sys_clk(i_sys_clk),
	.i_rst_b(i_rst_b), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel),
	.i_wb_we(i_wb_we), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat),
	.o_wb_ack(o_wb_ack), .i_rx_pin(i_rx_pin), .o_stop_sixteenths(o_stop_sixteenths),
	.o_stop_two_bits(o_stop_two_bits), .o_rx_full(o_rx_full), .o_rx_overrun(o_rx_overrun));

// *** tb/usr_stop_rx_fifo_full_threshold_test.sv ***
`timescale 1ns/1ps
module usr_stop_rx_fifo_full_threshold_test;
	logic        clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00, b;
	logic [31:0] wdat = 32'h0, rd, o_dat;
	logic [3:0]  sel = 4'hf;
	logic [4:0]  six;
	logic        ack, two, full, ovr, line;
	logic [7:0]  modes [4] = '{8'h34, 8'h3c, 8'h35, 8'h30};
	int          err_total = 0, compares = 0, seed = 13778, ctl, lvl, bps, e, q[$];

	usr_stop_rx_fifo_full_threshold usr_stop_rx_fifo_full_threshold_i (.i_sys_clk(clk), .i_rst_b(rst_b), .i_wb_adr(adr),
		.i_wb_dat(wdat), .i_wb_sel(sel), .i_wb_we(we), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.o_wb_dat(o_dat), .o_wb_ack(ack), .i_rx_pin(line), .o_stop_sixteenths(six),
		.o_stop_two_bits(two), .o_rx_full(full), .o_rx_overrun(ovr));
	usr_line_model usr_line_model_i (.i_sys_clk(clk), .o_line(line));

	// 100 ns clock
	initial forever #50 clk = ~clk;

	task automatic results();
		$display("mismatches %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Classic single cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		@(posedge clk);
		while (ack !== 1'b1) begin
			n++;
			if (n > 20) begin
				err_total++;
				results();
			end
			@(posedge clk);
		end
		rd = o_dat;
		{cyc, stb} <= 2'b00;
		@(posedge clk);
	endtask

	// Total stop length in sixteenths
	function automatic int exp_stop(input int c, input int code);
		if (c & 1) return 16;
		if (c & 2) return (code & 8) ? 32 : 16;
		return (code >= 8 || (c & 8'h30) == 0) ? 17 + code : 9 + code;
	endfunction

	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		wb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0);
		chk(two ? 32'h20 : {27'h0, six}, 32'h10);
		// Every control setting against every stop code
		for (int c = 0; c < 64; c++) begin
			wb(1'b1, 8'h00, c);
			for (int s = 0; s < 16; s++) begin
				wb(1'b1, 8'h10, s);
				repeat (2) @(posedge clk);
				chk(two ? 32'h20 : {27'h0, six}, exp_stop(c, s));
			end
		end
		// Threshold readback, disabled byte lane ignored
		sel <= 4'h0;
		wb(1'b1, 8'h04, 32'h5);
		sel <= 4'hf;
		wb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0);
		repeat (8) begin
			e = $random(seed);
			wb(1'b1, 8'h04, e);
			wb(1'b0, 8'h04, 32'h0);
			chk(rd, e & 31);
		end
		wb(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h0);
		// Fill and drain in each receive mode
		for (int i = 0; i < 4; i++) begin
			ctl = modes[i];
			bps = (ctl & 8) ? 2 : 1;
			lvl = ($unsigned($random(seed)) % 6 + 1) * bps - 1;
			wb(1'b1, 8'h00, ctl);
			wb(1'b1, 8'h04, lvl);
			for (int k = 1; k <= 7 * bps; k++) begin
				b = $random(seed);
				q.push_back(b);
				usr_line_model_i.send(b, 8);
				repeat (4) @(posedge clk);
				chk(full, (ctl & 4) != 0 && k / bps * bps > lvl);
			end
			repeat (7) begin
				wb(1'b0, 8'h0c, 32'h0);
				e = q.pop_front();
				if (bps == 2) e = e | (q.pop_front() << 8);
				chk(rd, e);
			end
			repeat (3) @(posedge clk);
			chk(full, 32'h0);
		end
		results();
	end
endmodule
